// ==== rtl/gms_sequencer.sv ====
// Contract
// [RULE1] Two modes; measure only while Active
// [RULE2] Host access works in both modes
// [RULE3] Either bus line high wakes device
// [RULE4] Sleep needs allow bit and bus low
// [RULE5] Bus-low delay between 1.5 and 2.2 s
// [RULE6] Host keeps bus active unless wanting sleep
// [RULE7] Slot sequence repeats back to back
// [RULE8] Divider reference on before aux conversion
// [RULE9] Internal temperature uses second aux slot, reference off
// [RULE10] Voltage-type sequence lasts 1760 ms
// [RULE11] Aux inputs alternate, each once per cycle
// [RULE12] Cell voltage refreshed every 880 ms
// [RULE13] Cell voltage twelve-bit magnitude, two bytes
// [RULE14] Voltage saturates at 7fff
// [RULE15] Every 1024th conversion measures offset
// [RULE16] Offset applied to following 1023 conversions; code leaves on-chip temperature results uncorrected
// [RULE17] Voltage result held during calibration
// [RULE18] Missing sample flagged for capacity logic
// [RULE19] Signed current over plus/minus 51.2 mV
// [RULE20] Current accumulated into charge total
// [RULE21] Current result refreshed every 880 ms
// [RULE22] Aux results eleven-bit, two bytes
// [RULE23] Temperature in eighth-degree steps, two bytes
// [RULE24] Shadow RAM holds profile and scale
`timescale 1ns/1ps
module gms_sequencer #(
  parameter int SLOT_CYC = gms_pkg::SLOT_CYC,
  parameter int PRE_CYC = gms_pkg::PRE_CYC,
  parameter int SLEEP_CYC = gms_pkg::SLEEP_CYC
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic sys_rst, // Async reset
  input wire logic scl_in, // Bus clock pin level
  input wire logic sda_in, // Bus data pin level
  input wire logic sleep_allow, // Sleep enable setting
  input wire logic temp_internal, // Use on-chip sensor in second aux slot
  output gms_pkg::gms_conv_req_s conv_req, // Voltage converter request
  input wire logic conv_done, // Voltage conversion finished
  input wire logic [15:0] conv_data, // Raw voltage-type result
  output logic cur_start, // Current conversion start
  output logic cur_cal, // Current conversion is offset cal
  input wire logic cur_done, // Current conversion finished
  input wire logic [15:0] cur_data, // Raw signed current result
  output logic active, // Device in Active mode
  output logic divider_reference_output, // Divider reference enable
  output gms_pkg::gms_meas_s meas, // Measurement results
  output logic [31:0] charge_acc, // Running charge total
  output logic v_update, // Voltage result refreshed
  output logic v_cal_gap, // Voltage sample skipped for cal
  input wire logic shadow_wr, // Shadow write strobe
  input wire logic [4:0] shadow_addr, // Shadow byte address
  input wire logic [7:0] shadow_wdata, // Shadow write data
  output logic [7:0] shadow_rdata, // Shadow read data
  output logic [7:0] scale_factor // Capacity scale byte
);
  localparam logic [23:0] SLOT_LAST = 24'(SLOT_CYC - 1);
  localparam logic [23:0] PRE_AT = 24'(PRE_CYC);
  localparam logic [25:0] LOW_LAST = 26'(SLEEP_CYC - 1);

  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  gms_pkg::gms_mode_e mode_r, mode_nxt;
  logic [25:0] low_r, low_nxt;
  logic [1:0] slot_r, slot_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic busy_r, busy_nxt, seen_r, seen_nxt, ref_r, ref_nxt;
  gms_pkg::gms_conv_req_s req_r, req_nxt, pend_r, pend_nxt;
  logic cbusy_r, cbusy_nxt, ccal_r, ccal_nxt, cst_r, cst_nxt;
  logic [9:0] vcnt_r, vcnt_nxt, ccnt_r, ccnt_nxt;
  logic [15:0] voff_r, voff_nxt, coff_r, coff_nxt;
  gms_pkg::gms_meas_s meas_r, meas_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic vup_r, vup_nxt, gap_r, gap_nxt;
  logic [7:0] shadow_mem [gms_pkg::SHADOW_DEPTH];
  logic [7:0] rd_r, scale_r;
  logic aux_slot, bus_high;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_m_r <= 1'b0;
      scl_s_r <= 1'b0;
      sda_m_r <= 1'b0;
      sda_s_r <= 1'b0;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
    end
  end

  assign bus_high = scl_s_r | sda_s_r;
  // Reference only for real aux inputs, never for the on-chip sensor
  assign aux_slot = (slot_r == gms_pkg::SLOT_A0) ||
                    (slot_r == gms_pkg::SLOT_A1 && !temp_internal); // RULE9

  always_comb begin
    mode_nxt = mode_r;
    low_nxt = '0;
    unique case (mode_r)
      gms_pkg::GMS_SLEEP: begin
        if (bus_high) begin
          mode_nxt = gms_pkg::GMS_ACTIVE; // RULE3
        end
      end
      gms_pkg::GMS_ACTIVE: begin
        if (sleep_allow && !bus_high) begin
          low_nxt = low_r + 26'h1;
          if (low_r == LOW_LAST) begin
            mode_nxt = gms_pkg::GMS_SLEEP; // RULE4 RULE5
            low_nxt = '0;
          end
        end
      end
    endcase
  end

  always_comb begin
    slot_nxt = slot_r;
    tmr_nxt = tmr_r + 24'h1;
    busy_nxt = busy_r;
    seen_nxt = seen_r;
    req_nxt = '{start: 1'b0, cal: pend_r.cal, chan: pend_r.chan};
    pend_nxt = pend_r;
    cbusy_nxt = cbusy_r;
    ccal_nxt = ccal_r;
    cst_nxt = 1'b0;
    vcnt_nxt = vcnt_r;
    ccnt_nxt = ccnt_r;
    voff_nxt = voff_r;
    coff_nxt = coff_r;
    meas_nxt = meas_r;
    acc_nxt = acc_r;
    vup_nxt = 1'b0;
    gap_nxt = 1'b0;
    ref_nxt = 1'b0;
    if (mode_r == gms_pkg::GMS_SLEEP) begin
      slot_nxt = gms_pkg::SLOT_V0; // RULE1
      tmr_nxt = '0;
      busy_nxt = 1'b0;
      seen_nxt = 1'b0;
      cbusy_nxt = 1'b0;
    end else begin
      if (tmr_r == SLOT_LAST) begin
        tmr_nxt = '0;
        slot_nxt = slot_r + 2'h1; // RULE7 RULE10 RULE11
        seen_nxt = 1'b0;
      end
      // Reference rises at slot start, conversion waits one settle time
      ref_nxt = aux_slot && !seen_r && tmr_r != SLOT_LAST; // RULE8
      if (tmr_r == PRE_AT && !busy_r) begin
        req_nxt.start = 1'b1;
        req_nxt.cal = (vcnt_r == gms_pkg::CAL_IDX); // RULE15
        unique case (slot_r)
          gms_pkg::SLOT_A0: req_nxt.chan = gms_pkg::CH_AUX0;
          gms_pkg::SLOT_A1: req_nxt.chan = temp_internal ? gms_pkg::CH_TEMP
                                                         : gms_pkg::CH_AUX1; // RULE9
          default: req_nxt.chan = gms_pkg::CH_VOLT; // RULE12
        endcase
        pend_nxt = req_nxt;
        busy_nxt = 1'b1;
        vcnt_nxt = vcnt_r + 10'h1;
      end
      if (conv_done && busy_r) begin
        busy_nxt = 1'b0;
        seen_nxt = 1'b1;
        if (pend_r.cal) begin
          voff_nxt = conv_data; // RULE16
          gap_nxt = (pend_r.chan == gms_pkg::CH_VOLT); // RULE17 RULE18
        end else begin
          unique case (pend_r.chan)
            gms_pkg::CH_VOLT: begin
              meas_nxt.voltage = gms_pkg::sat_sub(conv_data, voff_r); // RULE13 RULE14
              vup_nxt = 1'b1;
            end
            gms_pkg::CH_AUX0: meas_nxt.aux0 = gms_pkg::sat_sub(conv_data, voff_r); // RULE22
            gms_pkg::CH_AUX1: meas_nxt.aux1 = gms_pkg::sat_sub(conv_data, voff_r); // RULE22
            gms_pkg::CH_TEMP: meas_nxt.temperature = conv_data; // RULE23
          endcase
        end
      end
      // Current converter runs alongside, one start per pair of slots
      if (tmr_r == '0 && !slot_r[0] && !cbusy_r) begin
        cst_nxt = 1'b1; // RULE21
        ccal_nxt = (ccnt_r == gms_pkg::CAL_IDX); // RULE15
        ccnt_nxt = ccnt_r + 10'h1;
        cbusy_nxt = 1'b1;
      end
      if (cur_done && cbusy_r) begin
        cbusy_nxt = 1'b0;
        if (ccal_r) begin
          coff_nxt = cur_data; // RULE16
        end else begin
          meas_nxt.current = gms_pkg::sat_sub(cur_data, coff_r); // RULE19
          acc_nxt = acc_r + {{16{meas_nxt.current[15]}}, meas_nxt.current}; // RULE20
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= gms_pkg::GMS_ACTIVE;
      low_r <= '0;
      slot_r <= gms_pkg::SLOT_V0;
      tmr_r <= '0;
      busy_r <= 1'b0;
      seen_r <= 1'b0;
      ref_r <= 1'b0;
      req_r <= '0;
      pend_r <= '0;
      cbusy_r <= 1'b0;
      ccal_r <= 1'b0;
      cst_r <= 1'b0;
      vcnt_r <= '0;
      ccnt_r <= '0;
      voff_r <= gms_pkg::OFF_RST;
      coff_r <= gms_pkg::OFF_RST;
      meas_r <= '0;
      acc_r <= gms_pkg::ACC_RST;
      vup_r <= 1'b0;
      gap_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      low_r <= low_nxt;
      slot_r <= slot_nxt;
      tmr_r <= tmr_nxt;
      busy_r <= busy_nxt;
      seen_r <= seen_nxt;
      ref_r <= ref_nxt;
      req_r <= req_nxt;
      pend_r <= pend_nxt;
      cbusy_r <= cbusy_nxt;
      ccal_r <= ccal_nxt;
      cst_r <= cst_nxt;
      vcnt_r <= vcnt_nxt;
      ccnt_r <= ccnt_nxt;
      voff_r <= voff_nxt;
      coff_r <= coff_nxt;
      meas_r <= meas_nxt;
      acc_r <= acc_nxt;
      vup_r <= vup_nxt;
      gap_r <= gap_nxt;
    end
  end

  // Shadow copy is reachable regardless of power mode
  always_ff @(posedge mclk) begin
    if (shadow_wr) begin
      shadow_mem[shadow_addr] <= shadow_wdata; // RULE2 RULE24
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_r <= gms_pkg::BYTE_RST;
      scale_r <= gms_pkg::BYTE_RST;
    end else begin
      rd_r <= shadow_mem[shadow_addr]; // RULE2
      scale_r <= shadow_mem[gms_pkg::SCALE_ADDR]; // RULE24
    end
  end

  assign conv_req = req_r;
  assign cur_start = cst_r;
  assign cur_cal = ccal_r;
  assign active = (mode_r == gms_pkg::GMS_ACTIVE);
  assign divider_reference_output = ref_r;
  assign meas = meas_r;
  assign charge_acc = acc_r;
  assign v_update = vup_r;
  assign v_cal_gap = gap_r;
  assign shadow_rdata = rd_r;
  assign scale_factor = scale_r;

  logic [23:0] ref_cnt_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_r <= '0;
    end else begin
      ref_cnt_r <= ref_r ? ref_cnt_r + 24'h1 : '0;
    end
  end

  a_wake_on_bus: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
    (mode_r == gms_pkg::GMS_SLEEP && bus_high) |=> active)
    else $error("no wake on bus high");
  a_sleep_needs_allow: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
    $fell(active) |-> $past(sleep_allow) && !$past(bus_high))
    else $error("sleep without allow or with bus high");
  a_sleep_delay_len: assert property (@(posedge mclk) disable iff (sys_rst) // RULE5
    $fell(active) |-> $past(low_r) == LOW_LAST)
    else $error("sleep delay wrong");
  a_no_meas_sleep: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    !active |=> !conv_req.start && !cur_start && !divider_reference_output)
    else $error("activity while asleep");
  a_slot_wraps: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
    (active && tmr_r == SLOT_LAST && slot_r == gms_pkg::SLOT_A1 &&
     mode_nxt == gms_pkg::GMS_ACTIVE) |=> slot_r == gms_pkg::SLOT_V0 && tmr_r == '0)
    else $error("sequence did not restart");
  a_ref_settled: assert property (@(posedge mclk) disable iff (sys_rst) // RULE8
    (conv_req.start && (conv_req.chan == gms_pkg::CH_AUX0 || conv_req.chan == gms_pkg::CH_AUX1))
    |-> ref_r && ref_cnt_r >= PRE_AT - 24'h1)
    else $error("reference not settled");
  a_temp_ref_off: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
    (slot_r == gms_pkg::SLOT_A1 && $stable(temp_internal) && temp_internal) |=> !ref_r)
    else $error("reference on for temperature");
  a_cal_period: assert property (@(posedge mclk) disable iff (sys_rst) // RULE15
    conv_req.start |-> conv_req.cal == ($past(vcnt_r) == gms_pkg::CAL_IDX))
    else $error("cal not every 1024th");
  // Cal may fall in any slot; the gap flag marks only a skipped voltage slot
  a_cal_holds_v: assert property (@(posedge mclk) disable iff (sys_rst) // RULE17 RULE18
    (conv_done && busy_r && pend_r.cal && active) |=> $stable(meas.voltage) ##0 !v_update
    ##0 (v_cal_gap == ($past(pend_r.chan) == gms_pkg::CH_VOLT)))
    else $error("voltage changed during cal");
  a_acc_adds: assert property (@(posedge mclk) disable iff (sys_rst) // RULE20
    (cur_done && cbusy_r && !ccal_r && active) |=>
    charge_acc == $past(acc_r) + {{16{meas.current[15]}}, meas.current})
    else $error("charge not accumulated");

  c_sleep_entry: cover property (@(posedge mclk) disable iff (sys_rst) $fell(active));
  c_cal_conv: cover property (@(posedge mclk) disable iff (sys_rst) conv_req.start && conv_req.cal);
  c_aux_ref: cover property (@(posedge mclk) disable iff (sys_rst)
    conv_req.start && conv_req.chan == gms_pkg::CH_AUX1 && ref_r);
endmodule

// ==== rtl/gms_pkg.sv ====
package gms_pkg;
  localparam int CLK_KHZ = 25000;
  localparam int SEQ_MS = 1760;
  localparam int SLOTS = 4;
  localparam int SEQ_CYC = SEQ_MS * CLK_KHZ;
  localparam int SLOT_CYC = SEQ_CYC / SLOTS;
  localparam int PRE_US = 13700;
  localparam int PRE_CYC = (PRE_US * CLK_KHZ + 999) / 1000;
  localparam int SLEEP_MS = 1500;
  localparam int SLEEP_CYC = SLEEP_MS * CLK_KHZ;
  localparam int TMR_W = 24;
  localparam int LOW_W = 26;
  localparam int CAL_W = 10;
  localparam logic [CAL_W-1:0] CAL_IDX = 10'h3ff;
  localparam logic [15:0] SAT_MAX = 16'h7fff;
  localparam logic [15:0] SAT_MIN = 16'h8000;
  localparam logic [15:0] OFF_RST = 16'h0000;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [1:0] SLOT_V0 = 2'h0;
  localparam logic [1:0] SLOT_A0 = 2'h1;
  localparam logic [1:0] SLOT_V1 = 2'h2;
  localparam logic [1:0] SLOT_A1 = 2'h3;
  localparam int SHADOW_DEPTH = 32;
  localparam int SHADOW_AW = 5;
  localparam logic [4:0] SCALE_ADDR = 5'h1f;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {CH_VOLT, CH_AUX0, CH_AUX1, CH_TEMP} gms_chan_e;
  typedef enum logic {GMS_ACTIVE, GMS_SLEEP} gms_mode_e;

  typedef struct packed {
    logic start;
    logic cal;
    gms_chan_e chan;
  } gms_conv_req_s;

  typedef struct packed {
    logic signed [15:0] voltage;
    logic signed [15:0] current;
    logic signed [15:0] aux0;
    logic signed [15:0] aux1;
    logic signed [15:0] temperature;
  } gms_meas_s;

  function automatic logic [15:0] sat_sub(input logic [15:0] raw, input logic [15:0] off);
    logic [16:0] d;
    d = {raw[15], raw} - {off[15], off};
    if (d[16] != d[15]) begin
      sat_sub = d[16] ? SAT_MIN : SAT_MAX;
    end else begin
      sat_sub = d[15:0];
    end
  endfunction
endpackage

// ==== verification/gms_conv_model.sv ====
`timescale 1ns/1ps
module gms_conv_model (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Async reset
  input gms_pkg::gms_conv_req_s conv_req, // Voltage converter request
  input wire logic cur_start, // Current conversion start
  input wire logic cur_cal, // Current offset cal
  input wire logic [7:0] lat, // Answer delay in cycles, at least 1
  input wire logic [15:0] v_val, // Voltage-type answer
  input wire logic [15:0] c_val, // Offset cal answer
  input wire logic [15:0] i_val, // Current answer
  output logic conv_done, // Voltage conversion done
  output logic [15:0] conv_data, // Voltage data
  output logic cur_done, // Current conversion done
  output logic [15:0] cur_data // Current data
);
  int vc;
  int ic;
  logic [15:0] vq;
  logic [15:0] iq;
  // Data lines show the inverted answer outside the done cycle
  assign conv_data = conv_done ? vq : ~vq;
  assign cur_data = cur_done ? iq : ~iq;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vc <= 0;
      ic <= 0;
      vq <= 16'h0000;
      iq <= 16'h0000;
      conv_done <= 1'b0;
      cur_done <= 1'b0;
    end else begin
      conv_done <= (vc == 1);
      cur_done <= (ic == 1);
      vc <= conv_req.start ? int'(lat) : (vc > 0 ? vc - 1 : 0);
      ic <= cur_start ? int'(lat) : (ic > 0 ? ic - 1 : 0);
      if (conv_req.start) begin
        vq <= conv_req.cal ? c_val : v_val;
      end
      if (cur_start) begin
        iq <= cur_cal ? c_val : i_val;
      end
    end
  end
endmodule

// ==== verification/gauge_measurement_sequencer_tb.sv ====
`timescale 1ns/1ps
module gauge_measurement_sequencer_tb;
  localparam int SC = 40;
  localparam int PC = 8;
  localparam int SLP = 50;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl_in = 1'b1;
  logic sda_in = 1'b1;
  logic sleep_allow = 1'b0;
  logic temp_internal = 1'b0;
  logic shadow_wr = 1'b0;
  logic [4:0] shadow_addr = 5'h00;
  logic [7:0] shadow_wdata = 8'h00;
  logic [7:0] lat = 8'h05;
  logic [15:0] v_val = 16'h0abc;
  logic [15:0] c_val = 16'h0000;
  logic [15:0] i_val = 16'hfff6;
  gms_pkg::gms_conv_req_s conv_req;
  gms_pkg::gms_meas_s meas;
  logic conv_done, cur_start, cur_cal, cur_done, active, ref_on, v_update, v_cal_gap;
  logic [15:0] conv_data, cur_data;
  logic [31:0] charge_acc;
  logic [7:0] shadow_rdata, scale_factor;
  int num_errors = 0;
  int check_count = 0;
  int nstart = 0;
  int nupd = 0;
  int ref_cnt = 0;
  int ngap = 0;
  int n;
  always #20 mclk = ~mclk;
  gms_sequencer #(.SLOT_CYC(SC), .PRE_CYC(PC), .SLEEP_CYC(SLP)) i_dut (.mclk(mclk),
    .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sleep_allow(sleep_allow),
    .temp_internal(temp_internal), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data), .cur_start(cur_start), .cur_cal(cur_cal), .cur_done(cur_done),
    .cur_data(cur_data), .active(active), .divider_reference_output(ref_on), .meas(meas),
    .charge_acc(charge_acc), .v_update(v_update), .v_cal_gap(v_cal_gap),
    .shadow_wr(shadow_wr), .shadow_addr(shadow_addr), .shadow_wdata(shadow_wdata),
    .shadow_rdata(shadow_rdata), .scale_factor(scale_factor));
  gms_conv_model i_conv (.mclk(mclk), .sys_rst(sys_rst), .conv_req(conv_req),
    .cur_start(cur_start), .cur_cal(cur_cal), .lat(lat), .v_val(v_val), .c_val(c_val),
    .i_val(i_val), .conv_done(conv_done), .conv_data(conv_data), .cur_done(cur_done),
    .cur_data(cur_data));
  // Starts, updates and reference lead time seen so far
  always @(negedge mclk) begin
    nstart <= nstart + int'(conv_req.start === 1'b1);
    nupd <= nupd + int'(v_update === 1'b1);
    ngap <= ngap + int'(v_cal_gap === 1'b1);
    ref_cnt <= (ref_on === 1'b1 && conv_req.start !== 1'b1) ? ref_cnt + 1 : 0;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wait_start(output int gap);
    gap = 0;
    do begin
      @(negedge mclk);
      gap++;
    end while (conv_req.start !== 1'b1 && gap < 4 * SC);
    chk(conv_req.start, 1'b1);
  endtask
  task automatic t_seq;
    gms_pkg::gms_chan_e exp_ch [4];
    int g;
    int u0;
    exp_ch = '{gms_pkg::CH_VOLT, gms_pkg::CH_AUX0, gms_pkg::CH_VOLT, gms_pkg::CH_AUX1};
    wait_start(g);
    u0 = nupd;
    for (int i = 1; i < 9; i++) begin
      wait_start(g);
      chk(g, SC);
      chk(conv_req.chan, exp_ch[i % 4]);
      chk(ref_cnt, (i % 2) ? PC : 0);
    end
    chk(nupd - u0, 4);
    chk(meas.voltage[15:0], 16'h0abc);
    chk(meas.aux0[15:0], 16'h0abc);
    chk(meas.aux1[15:0], 16'h0abc);
    $display("t_seq done");
  endtask
  task automatic t_temp;
    int g;
    step(1);
    temp_internal = 1'b1;
    v_val = 16'h00c8;
    repeat (3) wait_start(g);
    chk(conv_req.chan, gms_pkg::CH_TEMP);
    chk(ref_cnt, 0);
    step(int'(lat) + 3);
    chk(meas.temperature[15:0], 16'h00c8);
    chk(ref_on, 1'b0);
    temp_internal = 1'b0;
    $display("t_temp done");
  endtask
  task automatic t_cur;
    logic [31:0] acc0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cur_start !== 1'b1 && n < 4 * SC);
    acc0 = charge_acc;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cur_done !== 1'b1 && n < SC);
    @(negedge mclk);
    chk(meas.current[15:0], i_val);
    chk(charge_acc, acc0 + {{16{i_val[15]}}, i_val});
    do begin
      @(negedge mclk);
      n++;
    end while (cur_start !== 1'b1 && n < 4 * SC);
    chk(n + 1, 2 * SC);
    $display("t_cur done");
  endtask
  task automatic t_cal;
    int g;
    logic [15:0] a1;
    step(1);
    lat = 8'h14;
    v_val = 16'h7ff8;
    c_val = 16'hfff0;
    do begin
      wait_start(g);
      a1 = meas.aux1[15:0];
    end while (conv_req.cal !== 1'b1 && nstart < 1100);
    chk(nstart, 1023);
    step(int'(lat) + 3);
    chk(meas.aux1[15:0], a1);
    chk(meas.voltage[15:0], 16'h7ff8);
    // 1024th start since reset lands in the second aux slot: no voltage gap
    chk(ngap, 0);
    wait_start(g);
    step(int'(lat) + 3);
    chk(meas.voltage[15:0], 16'h7fff);
    $display("t_cal done");
  endtask
  task automatic t_sleep;
    step(1);
    scl_in = 1'b0;
    sda_in = 1'b0;
    step(SLP + 20);
    chk(active, 1'b1);
    sleep_allow = 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (active !== 1'b0 && n < 4 * SLP);
    chk(n >= SLP && n <= SLP + 4, 1'b1);
    n = nstart;
    step(3 * SC);
    chk(nstart, n);
    shadow_wr = 1'b1;
    shadow_addr = gms_pkg::SCALE_ADDR;
    shadow_wdata = 8'h5a;
    step(1);
    shadow_addr = 5'h03;
    shadow_wdata = 8'ha5;
    step(1);
    shadow_wr = 1'b0;
    step(1);
    chk(shadow_rdata, 8'ha5);
    chk(scale_factor, 8'h5a);
    sda_in = 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (active !== 1'b1 && n < 10);
    chk(n >= 3 && n <= 4, 1'b1);
    scl_in = 1'b1;
    $display("t_sleep done");
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    chk({active, ref_on, meas[15:0]}, 18'h20000);
    #1;
    sys_rst = 1'b0;
    t_seq();
    t_temp();
    t_cur();
    t_cal();
    t_sleep();
    close_out();
  end
  initial begin
    // About 1030 slots of run time, with margin
    repeat (1200 * SC) @(posedge mclk);
    num_errors++;
    close_out();
  end
endmodule
